// *** hw/baud_tick_gen.sv ***
// Purpose: prescaler select and half-bit tick generator
// Assumes: divisor held stable while the channel runs
// Notes:   two ticks per serial bit
`timescale 1ns/1ps
`default_nettype none
`include "uart_baud_params.svh"
module baud_tick_gen (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       run,
	input  wire logic       restart,
	input  wire logic       srcSel,
	input  wire logic [7:0] prescaler,
	input  wire logic [6:0] divisor,
	output logic            halfTick
);
	logic [14:0] preCount_r;
	logic [3:0]  power;
	logic        opClkEn;
	logic [6:0]  divCount_r;

	assign power = srcSel ? prescaler[`PRS_HIGH_LSB +: 4] : prescaler[`PRS_LOW_LSB +: 4];

	always_ff @(posedge clock) begin
		if (!resetn) begin
			preCount_r <= 15'h0000;
		end else begin
			preCount_r <= preCount_r + 15'h0001;
		end
	end

	// operation clock enable: fclk / 2^power
	always_comb begin
		logic [14:0] lowMask;
		lowMask = 15'h0000;
		lowMask = (15'h0001 << power) - 15'h0001;
		opClkEn = (preCount_r & lowMask) == lowMask;
	end

	always_ff @(posedge clock) begin
		if (!resetn || !run || restart) begin
			divCount_r <= divisor;
			halfTick   <= 1'b0;
		end else if (opClkEn) begin
			if (divCount_r == 7'h00) begin
				divCount_r <= divisor;
				halfTick   <= 1'b1;
			end else begin
				divCount_r <= divCount_r - 7'h01;
				halfTick   <= 1'b0;
			end
		end else begin
			halfTick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** hw/uart_baud_and_error_control.sv ***
// Purpose: baud generation, prescaler select, receive sampling and error flags of one channel
// Assumes: rxd synchronous to clock; APB slave with zero wait states
// Notes:   interrupt is high while an unmasked status bit is set
`timescale 1ns/1ps
`default_nettype none
`include "uart_baud_params.svh"
// Contract
// - bit rate is operation clock over divisor plus one, halved
// - mode bit 15 selects low or high prescaler field; fclk over 2^p
// - sample points follow divisor after start bit; stop before last point
// - data register read clears buffer full and re-enables reception
// - writing one to flag-clear bit clears matching error flag
// - halt bit clears active and stops; launch bit sets active and runs
module uart_baud_and_error_control (
	input  wire logic                   clock,
	input  wire logic                   resetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [`ADDR_WIDTH-1:0] paddr,
	input  wire logic [31:0]            pwdata,
	output logic      [31:0]            prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  wire logic                   rxd,
	output logic                        irq
);
	logic [6:0]  divisor_r;
	logic        srcSel_r;
	logic [7:0]  prescaler_r;
	logic        active_r;
	logic [2:0]  errFlags_r;
	logic        full_r;
	logic [7:0]  rxData_r;
	logic [3:0]  mask_r;
	logic [1:0]  ctl_r;
	logic        halfTick;
	logic        wrEn;
	logic        rdEn;
	logic        mapped;
	uart_baud_pkg::rx_state_type state_r;
	logic [3:0]  bitCnt_r;
	logic        phase_r;
	logic [7:0]  shift_r;
	logic        parAcc_r;
	logic        frameDone;
	logic        setFrame;
	logic        setParity;
	logic        setOverrun;
	logic        startSeen;
	logic [3:0]  statusBits;
	logic        dataRead;

	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign mapped = (paddr <= `OFF_CHAN_CONTROL) && (paddr[1:0] == 2'b00);
	assign pslverr = psel && penable && !mapped;

	baud_tick_gen u_tick (
		.clock     (clock),
		.resetn    (resetn),
		.run       (active_r),
		.restart   (startSeen),
		.srcSel    (srcSel_r),
		.prescaler (prescaler_r),
		.divisor   (divisor_r),
		.halfTick  (halfTick)
	);

	// configuration registers
	always_ff @(posedge clock) begin
		if (!resetn) begin
			divisor_r   <= `RST_DIVISOR;
			srcSel_r    <= `RST_MODE_SEL;
			prescaler_r <= `RST_PRESCALER;
			mask_r      <= 4'h0;
			ctl_r       <= 2'b00;
		end else if (wrEn) begin
			case (paddr)
				`OFF_DATA_DIVISOR: divisor_r   <= pwdata[`DIV_MSB:`DIV_LSB];
				`OFF_MODE:         srcSel_r    <= pwdata[`SRC_SEL_BIT];
				`OFF_PRESCALER:    prescaler_r <= pwdata[7:0];
				`OFF_IRQ_MASK:     mask_r      <= pwdata[3:0];
				`OFF_CHAN_CONTROL: ctl_r       <= pwdata[1:0];
				default: ;
			endcase
		end
	end

	// channel enable status
	always_ff @(posedge clock) begin
		if (!resetn) begin
			active_r <= 1'b0;
		end else if (wrEn && paddr == `OFF_HALT && pwdata[0]) begin
			active_r <= 1'b0;
		end else if (wrEn && paddr == `OFF_LAUNCH && pwdata[0]) begin
			active_r <= 1'b1;
		end
	end

	// receiver: phase_r 0..1 picks half, full bit; samples at bit centres
	assign startSeen = active_r && state_r == uart_baud_pkg::RX_IDLE && !rxd;
	always_ff @(posedge clock) begin
		if (!resetn || !active_r) begin
			state_r  <= uart_baud_pkg::RX_IDLE;
			bitCnt_r <= 4'h0;
			phase_r  <= 1'b0;
			shift_r  <= 8'h00;
			parAcc_r <= 1'b0;
		end else begin
			case (state_r)
				uart_baud_pkg::RX_IDLE: begin
					if (!rxd) begin
						state_r <= uart_baud_pkg::RX_START;
						phase_r <= 1'b0;
					end
				end
				uart_baud_pkg::RX_START: begin
					if (halfTick) begin
						// start bit centre: confirm low
						state_r  <= rxd ? uart_baud_pkg::RX_IDLE : uart_baud_pkg::RX_DATA;
						bitCnt_r <= 4'h0;
						phase_r  <= 1'b0;
						parAcc_r <= ctl_r[`CTL_ODD_BIT];
					end
				end
				uart_baud_pkg::RX_DATA: begin
					if (halfTick) begin
						phase_r <= !phase_r;
						if (phase_r) begin
							shift_r  <= {rxd, shift_r[7:1]};
							parAcc_r <= parAcc_r ^ rxd;
							bitCnt_r <= bitCnt_r + 4'h1;
							if (bitCnt_r == 4'(`DATA_BITS - 1)) begin
								state_r <= ctl_r[`CTL_PARITY_BIT] ? uart_baud_pkg::RX_PARITY
								                                   : uart_baud_pkg::RX_STOP;
							end
						end
					end
				end
				uart_baud_pkg::RX_PARITY: begin
					if (halfTick) begin
						phase_r <= !phase_r;
						if (phase_r) begin
							parAcc_r <= parAcc_r ^ rxd;
							state_r  <= uart_baud_pkg::RX_STOP;
						end
					end
				end
				uart_baud_pkg::RX_STOP: begin
					if (halfTick) begin
						phase_r <= !phase_r;
						if (phase_r) begin
							state_r <= uart_baud_pkg::RX_IDLE;
						end
					end
				end
				default: state_r <= uart_baud_pkg::RX_IDLE;
			endcase
		end
	end

	assign frameDone = active_r && state_r == uart_baud_pkg::RX_STOP && halfTick && phase_r;
	assign setFrame = frameDone && !rxd;
	assign setParity = frameDone && ctl_r[`CTL_PARITY_BIT] && parAcc_r;
	assign dataRead = rdEn && paddr == `OFF_DATA_DIVISOR;
	// a frame landing on a full buffer is dropped and counted as overrun, unless the data register is read in that cycle
	assign setOverrun = frameDone && full_r && !dataRead;

	// received data and buffer-full flag
	always_ff @(posedge clock) begin
		if (!resetn) begin
			full_r   <= 1'b0;
			rxData_r <= 8'h00;
		end else if (frameDone && !setOverrun) begin
			full_r   <= 1'b1;
			rxData_r <= shift_r;
		end else if (dataRead) begin
			full_r <= 1'b0;
		end
	end

	// sticky error flags: set wins over clear
	always_ff @(posedge clock) begin
		if (!resetn) begin
			errFlags_r <= 3'h0;
		end else begin
			errFlags_r <= (errFlags_r
				& ~((wrEn && paddr == `OFF_FLAG_CLEAR) ? pwdata[2:0] & `ST_ERR_MASK : 3'h0))
				| {setFrame, setParity, setOverrun};
		end
	end

	assign statusBits = {full_r, errFlags_r};
	assign irq = |(statusBits & mask_r);

	// read data latched in the setup cycle, held until the next read
	always_ff @(posedge clock) begin
		if (!resetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				`OFF_DATA_DIVISOR: prdata <= {16'h0000, divisor_r, 1'b0, rxData_r};
				`OFF_MODE:         prdata <= {16'h0000, srcSel_r, 15'h0000};
				`OFF_PRESCALER:    prdata <= {24'h00_0000, prescaler_r};
				`OFF_STATUS:       prdata <= {26'h000_0000, full_r, 2'b00, errFlags_r};
				`OFF_ACTIVE:       prdata <= {31'h0000_0000, active_r};
				`OFF_IRQ_MASK:     prdata <= {28'h000_0000, mask_r};
				`OFF_CHAN_CONTROL: prdata <= {30'h0000_0000, ctl_r};
				default:           prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** hw/uart_baud_params.svh ***
// Purpose: offsets, fields, reset values and counts of the baud and error control block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   definitions only
`ifndef UART_BAUD_PARAMS_SVH
`define UART_BAUD_PARAMS_SVH

`define ADDR_WIDTH        12
`define OFF_DATA_DIVISOR  12'h000
`define OFF_MODE          12'h004
`define OFF_PRESCALER     12'h008
`define OFF_STATUS        12'h00C
`define OFF_FLAG_CLEAR    12'h010
`define OFF_LAUNCH        12'h014
`define OFF_HALT          12'h018
`define OFF_ACTIVE        12'h01C
`define OFF_IRQ_MASK      12'h020
`define OFF_CHAN_CONTROL  12'h024

`define DIV_MSB           15
`define DIV_LSB           9
`define DATA_MSB          7
`define SRC_SEL_BIT       15
`define PRS_LOW_LSB       0
`define PRS_HIGH_LSB      4
`define ST_FRAME_BIT      2
`define ST_PARITY_BIT     1
`define ST_OVERRUN_BIT    0
`define ST_FULL_BIT       5
`define ST_ERR_MASK       3'h7
`define CTL_PARITY_BIT    0
`define CTL_ODD_BIT       1

`define RST_DIVISOR       7'h02
`define RST_PRESCALER     8'h00
`define RST_MODE_SEL      1'h0
`define DATA_BITS         8

`endif

// *** hw/uart_baud_pkg.sv ***
// Purpose: types shared by the baud and error control block
// Assumes: nothing
// Notes:   receiver states only
package uart_baud_pkg;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_type;
endpackage

// *** sim/testbench.sv ***
// Purpose: self-checking bench of the baud and error control block
// Assumes: apb master tasks, remote transmitter model on rxd
// Notes:   bit time is 2*(divisor+1)*2^p clocks
`timescale 1ns/1ps
`default_nettype none
`include "uart_baud_params.svh"
module testbench;
	logic                   clock, resetn, psel, penable, pwrite, pready, pslverr, rxd, irq;
	logic [`ADDR_WIDTH-1:0] paddr;
	logic [31:0]            pwdata, prdata, s;
	int                     failures, checks;
	int                     cycles = 0;
	localparam logic [31:0] zero = 32'h0000_0000;
	localparam logic [31:0] one = 32'h0000_0001;
	uart_baud_and_error_control uart_baud_and_error_control_i (.clock(clock), .resetn(resetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .irq(irq));
	uart_tx_model uart_tx_model_i (.clock(clock), .rxd(rxd));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task stop_test;
		if (failures == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task chkBit(input logic e);
		@(negedge clock);
		checks++;
		if (irq !== e) begin
			failures++;
			$display("mismatch t=%0t got=%h exp=%h", $time, irq, e);
		end
	endtask
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		s = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task t_reset;
		for (int i = 0; i < 10; i++) begin
			if (i < 4 || i > 6) begin
				acc(1'b0, 12'(i * 4), zero);
				chk(s, i == 0 ? 32'h0000_0400 : zero);
			end
		end
		acc(1'b0, 12'h028, zero);
		chk(s, zero);
	endtask
	task t_rx(input logic [6:0] d, input logic [7:0] prs, input logic src, input int bitClk);
		acc(1'b1, `OFF_DATA_DIVISOR, {16'h0000, d, 9'h000});
		acc(1'b1, `OFF_MODE, {16'h0000, src, 15'h0000});
		acc(1'b1, `OFF_PRESCALER, {24'h00_0000, prs});
		acc(1'b1, `OFF_LAUNCH, one);
		uart_tx_model_i.send(8'hA5, bitClk, 1'b1);
		repeat (4) @(posedge clock);
		acc(1'b0, `OFF_STATUS, zero);
		chk(s, 32'h0000_0020);
		acc(1'b0, `OFF_DATA_DIVISOR, zero);
		chk(s & 32'h0000_00FF, 32'h0000_00A5);
		acc(1'b0, `OFF_STATUS, zero);
		chk(s, zero);
		acc(1'b1, `OFF_HALT, one);
	endtask
	task t_err;
		acc(1'b1, `OFF_DATA_DIVISOR, 32'h0000_0400);
		acc(1'b1, `OFF_LAUNCH, one);
		uart_tx_model_i.send(8'h3C, 6, 1'b1);
		uart_tx_model_i.send(8'hC3, 6, 1'b1);
		acc(1'b0, `OFF_STATUS, zero);
		chk(s & 32'h0000_0027, 32'h0000_0021);
		acc(1'b0, `OFF_DATA_DIVISOR, zero);
		chk(s & 32'h0000_00FF, 32'h0000_003C);
		acc(1'b0, `OFF_STATUS, zero);
		acc(1'b1, `OFF_FLAG_CLEAR, s);
		acc(1'b0, `OFF_STATUS, zero);
		chk(s, zero);
		acc(1'b1, `OFF_IRQ_MASK, 32'h0000_0004);
		uart_tx_model_i.send(8'h55, 6, 1'b0);
		acc(1'b0, `OFF_STATUS, zero);
		chk(s & 32'h0000_0007, 32'h0000_0004);
		chkBit(1'b1);
		acc(1'b1, `OFF_FLAG_CLEAR, s);
		chkBit(1'b0);
		acc(1'b0, `OFF_DATA_DIVISOR, zero);
		acc(1'b1, `OFF_HALT, one);
		acc(1'b0, `OFF_ACTIVE, zero);
		chk(s, zero);
		uart_tx_model_i.send(8'h99, 6, 1'b1);
		acc(1'b0, `OFF_STATUS, zero);
		chk(s, zero);
		acc(1'b1, `OFF_LAUNCH, one);
		acc(1'b0, `OFF_ACTIVE, zero);
		chk(s, one);
	endtask
	task t_par;
		acc(1'b1, `OFF_IRQ_MASK, 32'h0000_0002);
		acc(1'b1, `OFF_CHAN_CONTROL, 32'h0000_0001);
		uart_tx_model_i.sendParity(8'hA5, 6, 1'b0);
		acc(1'b0, `OFF_STATUS, zero);
		chk(s, 32'h0000_0020);
		acc(1'b0, `OFF_DATA_DIVISOR, zero);
		chk(s & 32'h0000_00FF, 32'h0000_00A5);
		acc(1'b1, `OFF_CHAN_CONTROL, 32'h0000_0003);
		uart_tx_model_i.sendParity(8'hA5, 6, 1'b0);
		acc(1'b0, `OFF_STATUS, zero);
		chk(s, 32'h0000_0022);
		chkBit(1'b1);
		acc(1'b1, `OFF_FLAG_CLEAR, s);
		chkBit(1'b0);
		acc(1'b0, `OFF_DATA_DIVISOR, zero);
		chk(s & 32'h0000_00FF, 32'h0000_00A5);
		acc(1'b0, `OFF_STATUS, zero);
		chk(s, zero);
	endtask
	initial begin
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = zero;
		failures = 0;
		checks = 0;
		repeat (5) @(posedge clock);
		resetn <= 1'b1;
		t_reset;
		t_rx(7'h02, 8'h00, 1'b0, 6);
		t_rx(7'h05, 8'h31, 1'b0, 24);
		t_rx(7'h03, 8'h21, 1'b1, 32);
		t_rx(7'h7F, 8'h00, 1'b0, 256);
		t_err;
		t_par;
		stop_test;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			stop_test;
		end
	end
endmodule
`default_nettype wire

// *** sim/uart_baud_assertions.sv ***
// Purpose: port-level checks of the baud and error control block
// Assumes: zero wait state apb slave
// Notes:   bound to the top module
`timescale 1ns/1ps
`default_nettype none
`include "uart_baud_params.svh"
module uart_baud_assertions (
	input wire logic                   clock,
	input wire logic                   resetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [`ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire logic                   rxd,
	input wire logic                   irq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	logic bad;
	assign bad = paddr >= 12'h028 || paddr[1:0] != 2'h0;
	sequence launchW; psel && penable && pwrite && paddr == `OFF_LAUNCH && pwdata[0]; endsequence
	sequence haltW; psel && penable && pwrite && paddr == `OFF_HALT && pwdata[0]; endsequence
	sequence rdActive; psel && !penable && !pwrite && paddr == `OFF_ACTIVE; endsequence
	ready_high_a: assert property (psel && penable |-> pready) else $error("pready low");
	slverr_bad_a: assert property (psel && penable && bad |-> pslverr) else $error("no slverr");
	slverr_good_a: assert property (psel && penable && !bad |-> !pslverr) else $error("slverr");
	bad_read_zero_a: assert property (psel && !penable && !pwrite && bad |=> prdata == 32'h0000_0000)
		else $error("unmapped read data");
	rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("prdata moved");
	irq_fall_a: assert property ($fell(irq) |-> $past(psel && penable)) else $error("irq fell");
	launch_active_a: assert property (launchW ##2 rdActive |=> prdata[0]) else $error("not active");
	halt_idle_a: assert property (haltW ##2 rdActive |=> !prdata[0]) else $error("still active");
endmodule
bind uart_baud_and_error_control uart_baud_assertions uart_baud_assertions_i (.clock(clock),
	.resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .irq(irq));
`default_nettype wire

// *** sim/uart_tx_model.sv ***
// Purpose: remote transmitter driving the serial receive line
// Assumes: bit time given in clocks, idle line high
// Notes:   stop level of send chosen by caller to force framing errors; sendParity always sends a high stop
`timescale 1ns/1ps
`default_nettype none
module uart_tx_model (
	input  wire logic clock,
	output logic      rxd
);
	initial rxd = 1'b1;
	// start, eight bits lsb first, stop, then one idle bit
	task automatic send(input logic [7:0] b, input int bitClk, input logic stopLvl);
		logic [9:0] f;
		f = {stopLvl, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (bitClk) @(posedge clock);
		end
		rxd <= 1'b1;
		repeat (bitClk) @(posedge clock);
	endtask
	// start, eight bits lsb first, parity level given by caller, stop, one idle bit
	task automatic sendParity(input logic [7:0] b, input int bitClk, input logic par);
		logic [10:0] f;
		f = {1'b1, par, b, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rxd <= f[i];
			repeat (bitClk) @(posedge clock);
		end
		rxd <= 1'b1;
		repeat (bitClk) @(posedge clock);
	endtask
endmodule
`default_nettype wire
